// ---- rtl/flash_seg_pkg.sv ----
// Package with the flash map, segment geometry, calibration layout and op codes.
package flash_seg_pkg;
   localparam int ADDR_W = 16;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int INFO_SEG_BYTES = 64;
   localparam int MAIN_SEG_BYTES = 512;
   localparam int INFO_SEGS = 4;
   localparam logic [15:0] INFO_BASE = 16'h1000;
   localparam logic [15:0] INFO_LAST = 16'h10ff;
   localparam logic [15:0] MAIN_BASE = 16'hc000;
   localparam logic [1:0] SEG_A_INDEX = 2'h3;
   localparam logic [15:0] CONV_CAL_TAG_ADDR = 16'h10da;
   localparam logic [7:0] converter_cal_record_tag = 8'h10;
   localparam logic [15:0] OSC_CAL_TAG_ADDR = 16'h10f6;
   localparam logic [7:0] osc_cal_record_tag = 8'h01;
   localparam logic [7:0] EMPTY_TAG = 8'hfe;
   localparam logic [15:0] OFS_TUNE_16M = 16'h0002;
   localparam logic [15:0] OFS_RANGE_16M = 16'h0003;
   localparam logic [15:0] OFS_TUNE_12M = 16'h0004;
   localparam logic [15:0] OFS_RANGE_12M = 16'h0005;
   localparam logic [15:0] OFS_TUNE_8M = 16'h0006;
   localparam logic [15:0] OFS_RANGE_8M = 16'h0007;
   localparam logic [15:0] OFS_TUNE_1M = 16'h0008;
   localparam logic [15:0] OFS_RANGE_1M = 16'h0009;
   localparam logic [15:0] OFS_CONV_GAIN = 16'h0002;
   localparam logic [15:0] OFS_CONV_OFFSET = 16'h0004;
   localparam logic [15:0] OFS_REF15_FACTOR = 16'h0006;
   localparam logic [15:0] OFS_TEMP15_COOL = 16'h0008;
   localparam logic [15:0] OFS_TEMP15_HOT = 16'h000a;
   localparam logic [15:0] OFS_REF25_FACTOR = 16'h000c;
   localparam logic [15:0] OFS_TEMP25_COOL = 16'h000e;
   localparam logic [15:0] OFS_TEMP25_HOT = 16'h0010;
   localparam logic [2:0] OP_WRITE_BYTE = 3'h0;
   localparam logic [2:0] OP_WRITE_WORD = 3'h1;
   localparam logic [2:0] OP_ERASE_SEG = 3'h2;
   localparam logic [2:0] OP_ERASE_MAIN = 3'h3;
   localparam logic [2:0] OP_ERASE_ALL = 3'h4;
endpackage

// ---- rtl/flash_port_arb.sv ----
`timescale 1ns/1ps
// Fixed-priority selector between the CPU port and the debug programming port.
module flash_port_arb
   import flash_seg_pkg::*;
(
   // Debug port
   input wire logic i_dbg_req,
   input wire logic [2:0] i_dbg_op,
   input wire logic [15:0] i_dbg_addr,
   input wire logic [15:0] i_dbg_data,
   // Cpu port
   input wire logic i_cpu_req,
   input wire logic [2:0] i_cpu_op,
   input wire logic [15:0] i_cpu_addr,
   input wire logic [15:0] i_cpu_data,
   // Selected request
   output logic o_req,
   output logic o_from_dbg,
   output logic [2:0] o_op,
   output logic [15:0] o_addr,
   output logic [15:0] o_data
);
   // The debug port wins so an external programmer cannot be starved by a busy CPU.
   assign o_from_dbg = i_dbg_req;
   assign o_req = i_dbg_req | i_cpu_req;
   assign o_op = i_dbg_req ? i_dbg_op : i_cpu_op;
   assign o_addr = i_dbg_req ? i_dbg_addr : i_cpu_addr;
   assign o_data = i_dbg_req ? i_dbg_data : i_cpu_data;
endmodule

// ---- rtl/flash_segment_erase_protect.sv ----
`timescale 1ns/1ps
// Segmented flash array with erase, segment A lock and calibration record read-out.
//
// Contract
// - Array accepts programming from debug port and from CPU.
// - CPU may program a single byte or a single 16-bit word.
// - Information area has four 64-byte segments, A to D.
// - Main segments are 512 bytes; a segment is the smallest erase unit.
// - Erase clears one chosen main segment or all main segments.
// - Info segments erase singly, or all together with main erase.
// - Segment A refuses program and erase after reset until unlocked.
// - Converter record tag 0x10 sits at address 0x10DA.
// - Oscillator record tag 0x01 sits at address 0x10F6.
// - Tag 0xFE marks an unused calibration region.
// - Oscillator entries are bytes at offsets 2 to 9, tune even, range odd.
// - Converter entries are words at offsets 2 to 0x10.
module flash_segment_erase_protect
   import flash_seg_pkg::*;
#(
   parameter int MAIN_SEGS = 32
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Cpu port
   input wire logic i_cpu_req,
   input wire logic [2:0] i_cpu_op,
   input wire logic [15:0] i_cpu_addr,
   input wire logic [15:0] i_cpu_wdata,
   input wire logic i_cpu_rd,
   // Debug programming port
   input wire logic i_dbg_req,
   input wire logic [2:0] i_dbg_op,
   input wire logic [15:0] i_dbg_addr,
   input wire logic [15:0] i_dbg_wdata,
   // Lock control
   input wire logic i_seg_a_unlock,
   input wire logic i_seg_a_lock,
   // Status and read data
   output logic o_busy,
   output logic o_done,
   output logic o_refused,
   output logic o_seg_a_locked,
   output logic [15:0] o_rdata,
   output logic o_rvalid,
   output logic [7:0] o_osc_tag,
   output logic [7:0] o_conv_tag,
   output logic o_osc_rec_empty,
   output logic o_conv_rec_empty
);
   localparam int INFO_BYTES = INFO_SEGS * INFO_SEG_BYTES;
   localparam int MAIN_BYTES = MAIN_SEGS * MAIN_SEG_BYTES;
   localparam int MAIN_AW = $clog2(MAIN_BYTES);
   localparam int MSEG_W = $clog2(MAIN_SEGS);
   localparam int INFO_SHIFT = $clog2(INFO_SEG_BYTES);
   localparam int MAIN_SHIFT = $clog2(MAIN_SEG_BYTES);
   localparam logic [15:0] MAIN_LAST = MAIN_BASE + 16'(MAIN_BYTES - 1);
   localparam logic [15:0] INFO_BYTES_W = 16'(INFO_BYTES);
   localparam logic [15:0] MAIN_BYTES_W = 16'(MAIN_BYTES);
   localparam logic [15:0] ONE_W = 16'h0001;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ERASE = 3'b010,
      ST_DONE = 3'b100
   } state_t;

   logic [7:0] info_mem [INFO_BYTES];
   logic [7:0] main_mem [MAIN_BYTES];

   state_t state_reg, state_next;
   logic seg_a_locked_reg;
   logic [15:0] ers_ptr_reg;
   logic [15:0] ers_end_reg;
   logic ers_info_reg;
   logic ers_all_reg;
   logic busy_reg, done_reg, refused_reg, rvalid_reg, osc_empty_reg, conv_empty_reg;
   logic [15:0] rdata_reg;
   logic [7:0] osc_tag_reg, conv_tag_reg;

   // Request selection.
   logic req, from_dbg;
   logic [2:0] op;
   logic [15:0] addr, wdata;

   flash_port_arb u_arb (
      .i_dbg_req(i_dbg_req),
      .i_dbg_op(i_dbg_op),
      .i_dbg_addr(i_dbg_addr),
      .i_dbg_data(i_dbg_wdata),
      .i_cpu_req(i_cpu_req),
      .i_cpu_op(i_cpu_op),
      .i_cpu_addr(i_cpu_addr),
      .i_cpu_data(i_cpu_wdata),
      .o_req(req),
      .o_from_dbg(from_dbg),
      .o_op(op),
      .o_addr(addr),
      .o_data(wdata)
   );

   function automatic logic in_info(input logic [15:0] a);
      in_info = (a >= INFO_BASE) && (a <= INFO_LAST);
   endfunction

   function automatic logic in_main(input logic [15:0] a);
      in_main = (a >= MAIN_BASE) && (a <= MAIN_LAST);
   endfunction

   // Segment A is the top info segment, as calibration data sits at 0x10C0..0x10FF.
   function automatic logic in_seg_a(input logic [15:0] a);
      logic [15:0] rel;
      rel = a - INFO_BASE;
      in_seg_a = in_info(a) && (rel[INFO_SHIFT+1:INFO_SHIFT] == SEG_A_INDEX);
   endfunction

   wire [15:0] info_rel = addr - INFO_BASE;
   wire [15:0] main_rel = addr - MAIN_BASE;
   wire [15:0] info_rel_hi = info_rel + ONE_W;
   wire [15:0] main_rel_hi = main_rel + ONE_W;
   wire hit_info = in_info(addr);
   wire hit_main = in_main(addr);
   wire hit_seg_a = in_seg_a(addr) || ((op == OP_WRITE_WORD) && in_seg_a(addr + ONE_W));
   wire is_write = (op == OP_WRITE_BYTE) || (op == OP_WRITE_WORD);
   wire is_word = (op == OP_WRITE_WORD);
   wire is_ers_seg = (op == OP_ERASE_SEG);
   wire is_ers_main = (op == OP_ERASE_MAIN);
   wire is_ers_all = (op == OP_ERASE_ALL);
   // A mass erase with info leaves segment A alone while it is locked.
   wire blocked = seg_a_locked_reg && hit_seg_a && (is_write || is_ers_seg);
   wire take = i_ce && req && (state_reg == ST_IDLE);

   // Segment bounds for single-segment erase.
   wire [15:0] info_seg_start = {info_rel[15:INFO_SHIFT], {INFO_SHIFT{1'b0}}};
   wire [15:0] main_seg_start = {main_rel[15:MAIN_SHIFT], {MAIN_SHIFT{1'b0}}};
   wire [15:0] info_seg_end = info_seg_start + 16'(INFO_SEG_BYTES);
   wire [15:0] main_seg_end = main_seg_start + 16'(MAIN_SEG_BYTES);

   // Erase walker decode.
   wire ers_last = (ers_ptr_reg + ONE_W) == ers_end_reg;
   wire ers_in_a = ers_info_reg && seg_a_locked_reg &&
                   (ers_ptr_reg[INFO_SHIFT+1:INFO_SHIFT] == SEG_A_INDEX);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take) begin
               if (blocked || (!hit_info && !hit_main && !is_ers_main && !is_ers_all)) begin
                  state_next = ST_DONE;
               end else if (is_write) begin
                  state_next = ST_DONE;
               end else begin
                  state_next = ST_ERASE;
               end
            end
         end
         ST_ERASE: begin
            if (ers_last && !(ers_all_reg && !ers_info_reg)) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= ST_IDLE;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   // Lock comes back on every reset; lock request wins over unlock.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         seg_a_locked_reg <= 1'b1;
      end else if (i_ce) begin
         if (i_seg_a_lock) begin
            seg_a_locked_reg <= 1'b1;
         end else if (i_seg_a_unlock) begin
            seg_a_locked_reg <= 1'b0;
         end
      end
   end

   // Erase walker: one byte per cycle; an all-erase walks main then info.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ers_ptr_reg <= 16'h0000;
         ers_end_reg <= 16'h0000;
         ers_info_reg <= 1'b0;
         ers_all_reg <= 1'b0;
      end else if (i_ce) begin
         if (take && is_ers_seg && hit_info) begin
            ers_ptr_reg <= info_seg_start;
            ers_end_reg <= info_seg_end;
            ers_info_reg <= 1'b1;
            ers_all_reg <= 1'b0;
         end else if (take && is_ers_seg) begin
            ers_ptr_reg <= main_seg_start;
            ers_end_reg <= main_seg_end;
            ers_info_reg <= 1'b0;
            ers_all_reg <= 1'b0;
         end else if (take && (is_ers_main || is_ers_all)) begin
            ers_ptr_reg <= 16'h0000;
            ers_end_reg <= MAIN_BYTES_W;
            ers_info_reg <= 1'b0;
            ers_all_reg <= is_ers_all;
         end else if (state_reg == ST_ERASE) begin
            if (ers_last && ers_all_reg && !ers_info_reg) begin
               ers_ptr_reg <= 16'h0000;
               ers_end_reg <= INFO_BYTES_W;
               ers_info_reg <= 1'b1;
            end else begin
               ers_ptr_reg <= ers_ptr_reg + ONE_W;
            end
         end
      end
   end

   // Array writes. Programming only clears bits, as real flash cells do.
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         if (take && is_write && !blocked && hit_info) begin
            info_mem[info_rel[7:0]] <= info_mem[info_rel[7:0]] & wdata[7:0];
            if (is_word) begin
               info_mem[info_rel_hi[7:0]] <= info_mem[info_rel_hi[7:0]] & wdata[15:8];
            end
         end else if (take && is_write && !blocked && hit_main) begin
            main_mem[main_rel[MAIN_AW-1:0]] <= main_mem[main_rel[MAIN_AW-1:0]] & wdata[7:0];
            if (is_word) begin
               main_mem[main_rel_hi[MAIN_AW-1:0]] <=
                  main_mem[main_rel_hi[MAIN_AW-1:0]] & wdata[15:8];
            end
         end else if (state_reg == ST_ERASE && ers_info_reg && !ers_in_a) begin
            info_mem[ers_ptr_reg[7:0]] <= ERASED_BYTE;
         end else if (state_reg == ST_ERASE && !ers_info_reg) begin
            main_mem[ers_ptr_reg[MAIN_AW-1:0]] <= ERASED_BYTE;
         end
      end
   end

   // Status outputs.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else if (i_ce) begin
         busy_reg <= (state_next != ST_IDLE);
         done_reg <= (state_next == ST_DONE);
         if (take) begin
            refused_reg <= blocked;
         end
      end
   end

   // Read port: word read on the aligned pair, low byte at the even address.
   wire [15:0] rd_rel_i = {i_cpu_addr[15:1], 1'b0} - INFO_BASE;
   wire [15:0] rd_rel_m = {i_cpu_addr[15:1], 1'b0} - MAIN_BASE;
   wire [15:0] rd_rel_i1 = rd_rel_i + ONE_W;
   wire [15:0] rd_rel_m1 = rd_rel_m + ONE_W;
   wire [15:0] rd_word_i = {info_mem[rd_rel_i1[7:0]], info_mem[rd_rel_i[7:0]]};
   wire [15:0] rd_word_m = {main_mem[rd_rel_m1[MAIN_AW-1:0]], main_mem[rd_rel_m[MAIN_AW-1:0]]};
   wire rd_ok = i_cpu_rd && (state_reg == ST_IDLE);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else if (i_ce) begin
         rvalid_reg <= rd_ok;
         if (rd_ok) begin
            rdata_reg <= in_info(i_cpu_addr) ? rd_word_i :
                         (in_main(i_cpu_addr) ? rd_word_m : 16'h0000);
         end
      end
   end

   // Calibration record tags, watched continuously.
   wire [15:0] osc_rel = OSC_CAL_TAG_ADDR - INFO_BASE;
   wire [15:0] conv_rel = CONV_CAL_TAG_ADDR - INFO_BASE;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_tag_reg <= EMPTY_TAG;
         conv_tag_reg <= EMPTY_TAG;
         osc_empty_reg <= 1'b1;
         conv_empty_reg <= 1'b1;
      end else if (i_ce) begin
         osc_tag_reg <= info_mem[osc_rel[7:0]];
         conv_tag_reg <= info_mem[conv_rel[7:0]];
         osc_empty_reg <= (info_mem[osc_rel[7:0]] == EMPTY_TAG);
         conv_empty_reg <= (info_mem[conv_rel[7:0]] == EMPTY_TAG);
      end
   end

   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_refused = refused_reg;
   assign o_seg_a_locked = seg_a_locked_reg;
   assign o_rdata = rdata_reg;
   assign o_rvalid = rvalid_reg;
   assign o_osc_tag = osc_tag_reg;
   assign o_conv_tag = conv_tag_reg;
   assign o_osc_rec_empty = osc_empty_reg;
   assign o_conv_rec_empty = conv_empty_reg;

   // layout constants live in the package and bound these checks.
   sequence s_write_end;
      done_reg && busy_reg && !refused_reg;
   endsequence
   AST_LOCK_AFTER_RESET: assert property (@(posedge i_clk)
      $rose(i_resetn) |-> seg_a_locked_reg) else $error("lock not set after reset");
   AST_BLOCKED_DONE: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (take && blocked) |=> (done_reg && refused_reg)) else $error("blocked op not done");
   AST_WRITE_DONE: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (take && is_write && !blocked) |=> s_write_end) else $error("write did not complete");
   AST_ERASE_BUSY: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (take && is_ers_seg && !blocked && (hit_info || hit_main)) |=> busy_reg && !done_reg)
      else $error("erase not busy");
   AST_ERASE_BOUND: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state_reg == ST_ERASE) |-> (ers_ptr_reg < ers_end_reg)) else $error("erase overrun");
   AST_EMPTY_FLAG: assert property (@(posedge i_clk)
      i_ce && info_mem[osc_rel[7:0]] == EMPTY_TAG |=> o_osc_rec_empty) else $error("flag stale");
   AST_UNLOCK: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ce && i_seg_a_unlock && !i_seg_a_lock) |=> !seg_a_locked_reg)
      else $error("unlock ignored");
   AST_DONE_PULSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (done_reg && i_ce) |=> !done_reg) else $error("done longer than one cycle");
endmodule

// ---- dv/flash_req_model.sv ----
`timescale 1ns/1ps
// Requester model for one flash request port, holding each request until its completion.
module flash_req_model (
   // Clock
   input wire logic i_clk,
   // Answers from the flash
   input wire logic i_done,
   input wire logic i_rvalid,
   input wire logic [15:0] i_rdata,
   // Request lines
   output logic o_req,
   output logic [2:0] o_op,
   output logic [15:0] o_addr,
   output logic [15:0] o_data,
   output logic o_rd
);
   initial begin
      o_req = 1'b0;
      o_op = 3'h0;
      o_addr = 16'h0000;
      o_data = 16'h0000;
      o_rd = 1'b0;
   end
   // The request stays up until completion is seen, so a long erase is never retaken early.
   task automatic run(input logic [2:0] op, input logic [15:0] addr, input logic [15:0] data,
         output int n);
      n = 0;
      @(posedge i_clk);
      o_req <= 1'b1;
      o_op <= op;
      o_addr <= addr;
      o_data <= data;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_done !== 1'b1 && n < 4000);
      o_req <= 1'b0;
      // Released address and data lines show the inverse value, so nothing can lean on the old request.
      o_addr <= ~addr;
      o_data <= ~data;
   endtask
   task automatic read(input logic [15:0] addr, output logic [15:0] d, output logic v);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= addr;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      v = i_rvalid;
      d = i_rdata;
      o_addr <= ~addr;
   endtask
endmodule

// ---- dv/flash_segment_erase_protect_bench.sv ----
`timescale 1ns/1ps
// Self-checking bench for the segmented flash with segment A lock and calibration tags.
module flash_segment_erase_protect_bench;
   import flash_seg_pkg::*;
   localparam int SEGS = 2;
   logic clk;
   logic resetn;
   logic unlock;
   logic lock;
   logic ce;
   int fail_count;
   int total_checks;
   int cycles;
   int n;
   logic [15:0] rd;
   logic v;
   wire c_req, c_rd, d_req, busy, done, refused, locked, rvalid, osc_empty, conv_empty;
   wire [2:0] c_op, d_op;
   wire [15:0] c_addr, c_data, d_addr, d_data, rdata;
   wire [7:0] osc_tag, conv_tag;

   flash_req_model cpu_m (.i_clk(clk), .i_done(done), .i_rvalid(rvalid), .i_rdata(rdata),
      .o_req(c_req), .o_op(c_op), .o_addr(c_addr), .o_data(c_data), .o_rd(c_rd));
   flash_req_model dbg_m (.i_clk(clk), .i_done(done), .i_rvalid(rvalid), .i_rdata(rdata),
      .o_req(d_req), .o_op(d_op), .o_addr(d_addr), .o_data(d_data), .o_rd());
   flash_segment_erase_protect #(.MAIN_SEGS(SEGS)) dut_u (.i_clk(clk), .i_resetn(resetn),
      .i_ce(ce), .i_cpu_req(c_req), .i_cpu_op(c_op), .i_cpu_addr(c_addr),
      .i_cpu_wdata(c_data), .i_cpu_rd(c_rd), .i_dbg_req(d_req), .i_dbg_op(d_op),
      .i_dbg_addr(d_addr), .i_dbg_wdata(d_data), .i_seg_a_unlock(unlock),
      .i_seg_a_lock(lock), .o_busy(busy), .o_done(done), .o_refused(refused),
      .o_seg_a_locked(locked), .o_rdata(rdata), .o_rvalid(rvalid), .o_osc_tag(osc_tag),
      .o_conv_tag(conv_tag), .o_osc_rec_empty(osc_empty), .o_conv_rec_empty(conv_empty));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // The cycle count includes the edge at which completion is sampled.
   task automatic do_op(input logic [2:0] op, input logic [15:0] addr, input logic [15:0] data,
         input int exp_n, input logic exp_ref);
      cpu_m.run(op, addr, data, n);
      check("cycles", 16'(exp_n), 16'(n));
      check("refused", {15'h0, exp_ref}, {15'h0, refused});
   endtask
   task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
      cpu_m.read(addr, rd, v);
      check("rdata", exp, rd);
      check("rvalid", 16'h0001, {15'h0, v});
   endtask
   task automatic set_lock(input logic l);
      @(posedge clk);
      lock <= l;
      unlock <= ~l;
      @(posedge clk);
      lock <= 1'b0;
      unlock <= 1'b0;
      @(posedge clk);
      check("locked", {15'h0, l}, {15'h0, locked});
   endtask
   task automatic t_reset();
      check("locked", 16'h0001, {15'h0, locked});
      check("osc tag", 16'h00fe, {8'h0, osc_tag});
      check("conv tag", 16'h00fe, {8'h0, conv_tag});
      check("empty", 16'h0003, {14'h0, osc_empty, conv_empty});
      check("busy", 16'h0000, {15'h0, busy});
   endtask
   task automatic t_erase_all();
      set_lock(1'b0);
      do_op(OP_ERASE_ALL, 16'hc000, 16'h0000, SEGS * 512 + 258, 1'b0);
      rd_chk(16'h10c0, 16'hffff);
      rd_chk(16'hc3fe, 16'hffff);
   endtask
   task automatic t_refuse();
      set_lock(1'b1);
      // With the clock enable low an unlock request must not reach the lock.
      @(posedge clk);
      ce <= 1'b0;
      unlock <= 1'b1;
      repeat (2) @(posedge clk);
      check("frozen lock", 16'h0001, {15'h0, locked});
      ce <= 1'b1;
      unlock <= 1'b0;
      do_op(OP_WRITE_BYTE, 16'h10c2, 16'h0000, 2, 1'b1);
      do_op(OP_ERASE_SEG, 16'h10c0, 16'h0000, 2, 1'b1);
      rd_chk(16'h10c2, 16'hffff);
      // A word whose upper byte lands in segment A is refused as a whole.
      do_op(OP_WRITE_WORD, 16'h10bf, 16'h0000, 2, 1'b1);
      rd_chk(16'h10c0, 16'hffff);
   endtask
   task automatic t_writes();
      do_op(OP_WRITE_BYTE, 16'hc001, 16'h005a, 2, 1'b0);
      rd_chk(16'hc000, 16'h5aff);
      do_op(OP_WRITE_WORD, 16'hc011, 16'h1234, 2, 1'b0);
      rd_chk(16'hc010, 16'h34ff);
      rd_chk(16'hc012, 16'hff12);
      dbg_m.run(OP_WRITE_WORD, 16'hc202, 16'ha5c3, n);
      check("cycles", 16'h0002, 16'(n));
      rd_chk(16'hc202, 16'ha5c3);
   endtask
   task automatic t_seg_erase();
      do_op(OP_ERASE_SEG, 16'hc1ff, 16'h0000, 514, 1'b0);
      rd_chk(16'hc000, 16'hffff);
      rd_chk(16'hc202, 16'ha5c3);
   endtask
   task automatic t_cal();
      set_lock(1'b0);
      do_op(OP_WRITE_BYTE, OSC_CAL_TAG_ADDR, {8'h00, EMPTY_TAG}, 2, 1'b0);
      do_op(OP_WRITE_BYTE, CONV_CAL_TAG_ADDR, {8'h00, converter_cal_record_tag}, 2, 1'b0);
      repeat (2) @(posedge clk);
      check("osc empty", 16'h0001, {15'h0, osc_empty});
      check("conv tag", 16'h0010, {8'h0, conv_tag});
      check("conv empty", 16'h0000, {15'h0, conv_empty});
      do_op(OP_WRITE_WORD, CONV_CAL_TAG_ADDR + OFS_CONV_GAIN, 16'hbeef, 2, 1'b0);
      rd_chk(16'h10dc, 16'hbeef);
      do_op(OP_WRITE_BYTE, OSC_CAL_TAG_ADDR + OFS_RANGE_1M, 16'h0086, 2, 1'b0);
      do_op(OP_WRITE_BYTE, OSC_CAL_TAG_ADDR + OFS_TUNE_1M, 16'h00b2, 2, 1'b0);
      rd_chk(16'h10fe, 16'h86b2);
      do_op(OP_WRITE_BYTE, 16'h10bf, 16'h003c, 2, 1'b0);
      do_op(OP_ERASE_SEG, 16'h10c0, 16'h0000, 66, 1'b0);
      rd_chk(16'h10be, 16'h3cff);
      rd_chk(16'h10f6, 16'hffff);
      do_op(OP_WRITE_BYTE, OSC_CAL_TAG_ADDR, {8'h00, osc_cal_record_tag}, 2, 1'b0);
      repeat (2) @(posedge clk);
      check("osc tag", 16'h0001, {8'h0, osc_tag});
      check("osc empty", 16'h0000, {15'h0, osc_empty});
   endtask
   task automatic t_mass_locked();
      set_lock(1'b1);
      do_op(OP_ERASE_ALL, 16'hc000, 16'h0000, SEGS * 512 + 258, 1'b0);
      rd_chk(16'h10f6, 16'hff01);
      rd_chk(16'h10be, 16'hffff);
      do_op(OP_WRITE_BYTE, 16'h10be, 16'h0000, 2, 1'b0);
      do_op(OP_WRITE_WORD, 16'hc100, 16'h0000, 2, 1'b0);
      do_op(OP_ERASE_MAIN, 16'hc000, 16'h0000, SEGS * 512 + 2, 1'b0);
      rd_chk(16'hc100, 16'hffff);
      rd_chk(16'h10be, 16'hff00);
   endtask
   // A reset in mid-run must lock segment A again, whatever software did before.
   task automatic t_mid_reset();
      set_lock(1'b0);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      check("relocked", 16'h0001, {15'h0, locked});
      check("tag after reset", 16'h00fe, {8'h0, osc_tag});
      do_op(OP_WRITE_BYTE, 16'h10f7, 16'h0000, 2, 1'b1);
      rd_chk(16'h10f6, 16'hff01);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // A hung handshake ends the run here; the full sequence needs well under 8000 cycles.
   initial begin
      cycles = 0;
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles >= 20000) begin
            fail_count++;
            $display("wrong value run length expected 20000 seen %0d", cycles);
            report_and_stop();
         end
      end
   end
   initial begin
      fail_count = 0;
      total_checks = 0;
      resetn = 1'b0;
      unlock = 1'b0;
      lock = 1'b0;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_erase_all();
      t_refuse();
      t_writes();
      t_seg_erase();
      t_cal();
      t_mass_locked();
      t_mid_reset();
      report_and_stop();
   end
endmodule
